// file: logic/sar_pkg.sv
/*
 * Shared constants for the strain converter rate and status block:
 * register offsets, reset values, field positions and timing counts.
 * Assumes a 50 MHz pclk and a 32-bit APB register bus.
 */
package sar_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_RATE_MODE = 8'h00;
    localparam logic [7:0] OFF_CODED_RATE = 8'h04;
    localparam logic [7:0] OFF_FINE_RATE = 8'h08;
    localparam logic [7:0] OFF_STATE_FLAGS = 8'h0C;
    localparam logic [7:0] OFF_CONV_TIME = 8'h10;
    localparam logic [7:0] OFF_MS_CYCLE = 8'h14;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h1C;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h20;
    localparam logic [7:0] OFF_ANALOG = 8'h24;

    // Reset values
    localparam logic [15:0] RST_RATE_MODE = 16'h0000;
    localparam logic [7:0] RST_CODED_RATE = 8'h00;
    localparam logic [15:0] RST_FINE_RATE = 16'h0000;
    localparam logic [7:0] RST_MS_CYCLE = 8'h00;

    // Mode values
    localparam logic [15:0] MODE_CODED = 16'h0000;
    localparam logic [15:0] MODE_FINE = 16'h0001;

    // Module state flag positions
    localparam int FLG_INVALID = 0;
    localparam int FLG_OPEN = 1;
    localparam int FLG_SUPPLY = 3;
    localparam int FLG_EXCITE = 4;
    localparam int FLG_NOT_READY = 5;

    // Interrupt event positions
    localparam int EV_CONV = 0;
    localparam int EV_OPEN = 1;
    localparam int EV_SUPPLY = 2;
    localparam int EV_EXCITE = 3;
    localparam int EV_READY = 4;
    localparam int EV_W = 5;

    // Analog value shown instead of a measurement while the invalid flag is set (bad rate code, supply or excitation fault)
    localparam logic [15:0] INVALID_RANGE_VALUE = 16'h7FFF;

    // Timing
    localparam int CLK_HZ = 50_000_000;
    localparam int US_PER_S = 1_000_000;
    localparam int CYC_PER_US = CLK_HZ / US_PER_S;
    localparam int UPDATE_FAST_US = 50;
    localparam int UPDATE_SLOW_US = 100;
    // Rate units are 0.1 Hz, so a tick is due when the sum passes ten clock rates
    localparam int DHZ_PER_HZ = 10;
    localparam logic [29:0] RATE_WRAP = 30'(CLK_HZ * DHZ_PER_HZ);
    localparam int READY_TICKS = 4;

endpackage

// file: logic/sar_rate_gen.sv
/*
 * Phase accumulator that turns a rate in 0.1 Hz units into filter step pulses.
 * Assumes the rate input is steady between steps and pclk at 50 MHz.
 */
`timescale 1ns/10ps
module sar_rate_gen (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Rate
    input wire logic enable,
    input wire logic [16:0] rate_dhz,
    // Step
    output logic step_ff
);

    logic [29:0] acc_ff;
    logic [29:0] nxt_acc;

    always_comb begin
        nxt_acc = acc_ff + {13'h0000, rate_dhz};
    end

    // Remainder is kept on wrap so long-run rate stays exact
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_ff <= 30'h00000000;
            step_ff <= 1'b0;
        end else if (!enable) begin
            acc_ff <= 30'h00000000;
            step_ff <= 1'b0;
        end else if (nxt_acc >= sar_pkg::RATE_WRAP) begin
            acc_ff <= nxt_acc - sar_pkg::RATE_WRAP;
            step_ff <= 1'b1;
        end else begin
            acc_ff <= nxt_acc;
            step_ff <= 1'b0;
        end
    end

endmodule

// file: logic/sar_top.sv
/*
 * Rate selection, module state flags and conversion timestamp of a
 * single strain gauge converter, with an APB register slave and interrupt.
 * Assumes the converter's done pulse and raw data are synchronous to pclk;
 * the fault and open circuit pins are asynchronous and are synchronised here.
 */
`timescale 1ns/10ps

module sar_top (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Converter side
    input wire logic adc_done,
    input wire logic [23:0] adc_raw,
    // Monitor pins
    input wire logic open_circuit_pin,
    input wire logic supply_fault_pin,
    input wire logic excite_fault_pin,
    // Filter control
    output logic fir_enable,
    output logic fir_step,
    output logic filter_clear,
    // Results
    output logic [15:0] analog_value,
    output logic analog_strobe,
    output logic io_update,
    output logic irq
);

    logic [15:0] rate_mode_ff;
    logic [7:0] coded_rate_ff;
    logic [15:0] fine_rate_ff;
    logic [7:0] ms_cycle_ff;
    logic [sar_pkg::EV_W-1:0] irq_status_ff;
    logic [sar_pkg::EV_W-1:0] irq_enable_ff;
    logic [31:0] conv_time_ff;
    logic [15:0] analog_ff;
    logic analog_strobe_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [1:0] open_sync_ff;
    logic [1:0] supply_sync_ff;
    logic [1:0] excite_sync_ff;
    logic open_ff;
    logic supply_ff;
    logic excite_ff;
    logic [2:0] ready_cnt_ff;
    logic fir_enable_ff;
    logic filter_clear_ff;
    logic [6:0] upd_cnt_ff;
    logic io_update_ff;
    logic irq_ff;

    logic [16:0] rate_dhz;
    logic rate_on;
    logic code_bad;
    logic fault;
    logic not_ready;
    logic invalid;
    logic [7:0] state_flags;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [sar_pkg::EV_W-1:0] events;
    logic [sar_pkg::EV_W-1:0] clr_mask;
    logic step;
    logic us_tick;
    logic [31:0] us_count;
    logic [6:0] upd_period;

    // Coded rate in 0.1 Hz units; zero marks a code with no rate
    function automatic logic [16:0] code_to_dhz(input logic [3:0] code);
        logic [16:0] r;
        r = 17'h00000;
        unique case (code)
            4'h0: r = 17'h00019;
            4'h1: r = 17'h00032;
            4'h2: r = 17'h00064;
            4'h3: r = 17'h00096;
            4'h4: r = 17'h000FA;
            4'h5: r = 17'h0012C;
            4'h6: r = 17'h001F4;
            4'h7: r = 17'h00258;
            4'h8: r = 17'h003E8;
            4'h9: r = 17'h01388;
            4'hA: r = 17'h02710;
            4'hB: r = 17'h04E20;
            4'hC: r = 17'h0927C;
            4'hD: r = 17'h124F8;
            4'hE: r = 17'h00000;
            4'hF: r = 17'h00000;
        endcase
        return r;
    endfunction

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        return addr == off;
    endfunction

    // Rate selection and filter enable
    always_comb begin
        code_bad = 1'b0;
        if (rate_mode_ff == sar_pkg::MODE_FINE) begin
            rate_dhz = {1'b0, fine_rate_ff};
            rate_on = fine_rate_ff != 16'h0000;
        end else begin
            rate_dhz = code_to_dhz(coded_rate_ff[3:0]);
            code_bad = coded_rate_ff[3:0] >= 4'hE;
            rate_on = !code_bad;
        end
    end

    // Pin synchronisers; only the second stage is read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            open_sync_ff <= 2'h0;
            supply_sync_ff <= 2'h0;
            excite_sync_ff <= 2'h0;
        end else begin
            open_sync_ff <= {open_sync_ff[0], open_circuit_pin};
            supply_sync_ff <= {supply_sync_ff[0], supply_fault_pin};
            excite_sync_ff <= {excite_sync_ff[0], excite_fault_pin};
        end
    end

    // Registered copies give the edge detectors a previous value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            open_ff <= 1'b0;
            supply_ff <= 1'b0;
            excite_ff <= 1'b0;
        end else begin
            open_ff <= open_sync_ff[1];
            supply_ff <= supply_sync_ff[1];
            excite_ff <= excite_sync_ff[1];
        end
    end

    assign fault = supply_ff || excite_ff;

    // Filter runs only when a valid rate is chosen and supplies are good
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fir_enable_ff <= 1'b0;
            filter_clear_ff <= 1'b0;
        end else begin
            fir_enable_ff <= rate_on && !fault;
            filter_clear_ff <= fault;
        end
    end

    sar_rate_gen u_rate (
        .pclk(pclk),
        .presetn(presetn),
        .enable(fir_enable_ff),
        .rate_dhz(rate_dhz),
        .step_ff(step)
    );

    // Filter counts as ready after a few steps since it was last cleared or off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_cnt_ff <= 3'h0;
        end else if (!fir_enable_ff || filter_clear_ff) begin
            ready_cnt_ff <= 3'h0;
        end else if (step && ready_cnt_ff != 3'(sar_pkg::READY_TICKS)) begin
            ready_cnt_ff <= ready_cnt_ff + 3'h1;
        end
    end

    assign not_ready = fir_enable_ff && ready_cnt_ff != 3'(sar_pkg::READY_TICKS);
    assign invalid = code_bad || fault;

    always_comb begin
        state_flags = 8'h00;
        state_flags[sar_pkg::FLG_INVALID] = invalid;
        state_flags[sar_pkg::FLG_OPEN] = open_ff;
        state_flags[sar_pkg::FLG_SUPPLY] = supply_ff;
        state_flags[sar_pkg::FLG_EXCITE] = excite_ff;
        state_flags[sar_pkg::FLG_NOT_READY] = not_ready;
    end

    sar_us_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .us_tick_ff(us_tick),
        .us_count_ff(us_count)
    );

    // Conversion capture and timestamp
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_time_ff <= 32'h00000000;
            analog_ff <= 16'h0000;
            analog_strobe_ff <= 1'b0;
        end else begin
            analog_strobe_ff <= adc_done;
            if (adc_done) begin
                conv_time_ff <= us_count;
                analog_ff <= invalid ? sar_pkg::INVALID_RANGE_VALUE : adc_raw[23:8];
            end
        end
    end

    // I/O update pacing for the multisampling model
    assign upd_period = ms_cycle_ff[0] ? 7'(sar_pkg::UPDATE_SLOW_US) : 7'(sar_pkg::UPDATE_FAST_US);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upd_cnt_ff <= 7'h00;
            io_update_ff <= 1'b0;
        end else if (us_tick && upd_cnt_ff >= upd_period - 7'h01) begin
            upd_cnt_ff <= 7'h00;
            io_update_ff <= 1'b1;
        end else begin
            if (us_tick) begin
                upd_cnt_ff <= upd_cnt_ff + 7'h01;
            end
            io_update_ff <= 1'b0;
        end
    end

    // APB decode; one wait state so read data comes from a flip-flop
    assign addr_ok = hit(paddr, sar_pkg::OFF_RATE_MODE) || hit(paddr, sar_pkg::OFF_CODED_RATE)
        || hit(paddr, sar_pkg::OFF_FINE_RATE) || hit(paddr, sar_pkg::OFF_STATE_FLAGS)
        || hit(paddr, sar_pkg::OFF_CONV_TIME) || hit(paddr, sar_pkg::OFF_MS_CYCLE)
        || hit(paddr, sar_pkg::OFF_IRQ_STATUS) || hit(paddr, sar_pkg::OFF_IRQ_CLEAR)
        || hit(paddr, sar_pkg::OFF_IRQ_ENABLE) || hit(paddr, sar_pkg::OFF_ANALOG);
    assign wr_en = psel && penable && pready_ff && pwrite && addr_ok;
    assign rd_en = psel && penable && !pready_ff && !pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= psel && penable && !pready_ff;
            pslverr_ff <= psel && penable && !pready_ff && !addr_ok;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
        end else if (rd_en) begin
            prdata_ff <= 32'h00000000;
            unique case (1'b1)
                hit(paddr, sar_pkg::OFF_RATE_MODE): prdata_ff[15:0] <= rate_mode_ff;
                hit(paddr, sar_pkg::OFF_CODED_RATE): prdata_ff[7:0] <= coded_rate_ff;
                hit(paddr, sar_pkg::OFF_FINE_RATE): prdata_ff[15:0] <= fine_rate_ff;
                hit(paddr, sar_pkg::OFF_STATE_FLAGS): prdata_ff[7:0] <= state_flags;
                hit(paddr, sar_pkg::OFF_CONV_TIME): prdata_ff <= conv_time_ff;
                hit(paddr, sar_pkg::OFF_MS_CYCLE): prdata_ff[7:0] <= ms_cycle_ff;
                hit(paddr, sar_pkg::OFF_IRQ_STATUS): prdata_ff[sar_pkg::EV_W-1:0] <= irq_status_ff;
                hit(paddr, sar_pkg::OFF_IRQ_ENABLE): prdata_ff[sar_pkg::EV_W-1:0] <= irq_enable_ff;
                hit(paddr, sar_pkg::OFF_ANALOG): prdata_ff[15:0] <= analog_ff;
                default: prdata_ff <= 32'h00000000;
            endcase
        end
    end

    // Configuration registers; reserved bits are stored as written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_mode_ff <= sar_pkg::RST_RATE_MODE;
            coded_rate_ff <= sar_pkg::RST_CODED_RATE;
            fine_rate_ff <= sar_pkg::RST_FINE_RATE;
            ms_cycle_ff <= sar_pkg::RST_MS_CYCLE;
            irq_enable_ff <= '0;
        end else if (wr_en) begin
            if (hit(paddr, sar_pkg::OFF_RATE_MODE)) begin
                rate_mode_ff <= pwdata[15:0];
            end
            if (hit(paddr, sar_pkg::OFF_CODED_RATE)) begin
                coded_rate_ff <= pwdata[7:0];
            end
            if (hit(paddr, sar_pkg::OFF_FINE_RATE)) begin
                fine_rate_ff <= pwdata[15:0];
            end
            if (hit(paddr, sar_pkg::OFF_MS_CYCLE)) begin
                ms_cycle_ff <= pwdata[7:0];
            end
            if (hit(paddr, sar_pkg::OFF_IRQ_ENABLE)) begin
                irq_enable_ff <= pwdata[sar_pkg::EV_W-1:0];
            end
        end
    end

    // Events: conversion done, rising open circuit and faults, filter becoming ready
    always_comb begin
        events = '0;
        events[sar_pkg::EV_CONV] = adc_done;
        events[sar_pkg::EV_OPEN] = open_sync_ff[1] && !open_ff;
        events[sar_pkg::EV_SUPPLY] = supply_sync_ff[1] && !supply_ff;
        events[sar_pkg::EV_EXCITE] = excite_sync_ff[1] && !excite_ff;
        events[sar_pkg::EV_READY] = step && fir_enable_ff && !filter_clear_ff
            && ready_cnt_ff == 3'(sar_pkg::READY_TICKS - 1);
        clr_mask = '0;
        if (wr_en && hit(paddr, sar_pkg::OFF_IRQ_CLEAR)) begin
            clr_mask = pwdata[sar_pkg::EV_W-1:0];
        end
    end

    // A new event in the clearing cycle survives the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            irq_status_ff <= (irq_status_ff & ~clr_mask) | events;
            irq_ff <= |(((irq_status_ff & ~clr_mask) | events) & irq_enable_ff);
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign fir_enable = fir_enable_ff;
    assign fir_step = step;
    assign filter_clear = filter_clear_ff;
    assign analog_value = analog_ff;
    assign analog_strobe = analog_strobe_ff;
    assign io_update = io_update_ff;
    assign irq = irq_ff;

endmodule

// file: logic/sar_us_timer.sv
/*
 * Free running microsecond counter with a one-cycle tick per microsecond.
 * Assumes pclk at 50 MHz; the unsigned count wraps from all ones back to zero.
 */
`timescale 1ns/10ps
module sar_us_timer (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Time
    output logic us_tick_ff,
    output logic [31:0] us_count_ff
);

    logic [5:0] div_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= 6'h00;
            us_tick_ff <= 1'b0;
            us_count_ff <= 32'h00000000;
        end else if (div_ff == 6'(sar_pkg::CYC_PER_US - 1)) begin
            div_ff <= 6'h00;
            us_tick_ff <= 1'b1;
            us_count_ff <= us_count_ff + 32'h00000001;
        end else begin
            div_ff <= div_ff + 6'h01;
            us_tick_ff <= 1'b0;
        end
    end

endmodule

// file: testbench/sar_chk.sv
/*
 * Port checker for the rate, status and timestamp block.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/10ps
module sar_chk (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Converter and pins
    input wire logic adc_done,
    input wire logic supply_fault_pin,
    // Outputs
    input wire logic fir_enable,
    input wire logic fir_step,
    input wire logic filter_clear,
    input wire logic [15:0] analog_value,
    input wire logic analog_strobe,
    input wire logic io_update
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [12:0] io_gap_ff;
    logic io_seen_ff;

    // The first pulse after reset has no reference, so it is not judged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_gap_ff <= 13'h0;
            io_seen_ff <= 1'b0;
        end else if (io_update) begin
            io_gap_ff <= 13'h0;
            io_seen_ff <= 1'b1;
        end else begin
            io_gap_ff <= io_gap_ff + 13'h1;
        end
    end

    sequence s_wait;
        psel && penable && !pready;
    endsequence
    sequence s_done;
        psel && penable && pready;
    endsequence

    property p_apb_wait;
        $rose(penable) && psel |-> s_wait ##1 s_done;
    endproperty
    property p_slverr;
        pslverr |-> s_done;
    endproperty
    property p_strobe;
        analog_strobe == $past(adc_done);
    endproperty
    property p_fault_clear;
        supply_fault_pin [*5] |-> filter_clear;
    endproperty
    property p_fault_value;
        supply_fault_pin [*5] ##1 adc_done |=> analog_value == sar_pkg::INVALID_RANGE_VALUE;
    endproperty
    property p_fault_off;
        filter_clear [*2] |-> !fir_enable;
    endproperty
    property p_off_nostep;
        !fir_enable [*2] |-> !fir_step;
    endproperty
    property p_io_gap;
        io_update && io_seen_ff |-> io_gap_ff >= 13'h9C3 && io_gap_ff <= 13'h1387;
    endproperty
    property p_io_pulse;
        io_update |=> !io_update;
    endproperty

    a_apb_wait: assert property (p_apb_wait) else $error("access phase length wrong");
    a_slverr: assert property (p_slverr) else $error("error flag outside access end");
    a_strobe: assert property (p_strobe) else $error("strobe not one cycle after done");
    a_fault_clear: assert property (p_fault_clear) else $error("buffer not cleared on fault");
    a_fault_value: assert property (p_fault_value) else $error("value not invalid on fault");
    a_fault_off: assert property (p_fault_off) else $error("filter on during fault");
    a_off_nostep: assert property (p_off_nostep) else $error("step while filter off");
    a_io_gap: assert property (p_io_gap) else $error("update period out of range");
    a_io_pulse: assert property (p_io_pulse) else $error("update pulse too long");
endmodule

bind sar_top sar_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .adc_done(adc_done), .supply_fault_pin(supply_fault_pin),
    .fir_enable(fir_enable), .fir_step(fir_step), .filter_clear(filter_clear),
    .analog_value(analog_value), .analog_strobe(analog_strobe), .io_update(io_update));

// file: testbench/sar_fe_model.sv
/*
 * Converter front end model: conversion pulses with raw data, monitor pins.
 * Assumes one bench process calls its tasks.
 */
`timescale 1ns/10ps
module sar_fe_model (
    // Clock
    input wire logic pclk,
    // Converter side
    output logic adc_done,
    output logic [23:0] adc_raw,
    // Monitor pins
    output logic open_circuit_pin,
    output logic supply_fault_pin,
    output logic excite_fault_pin
);
    initial begin
        adc_done = 1'b0;
        adc_raw = 24'h5A5A5A;
        {open_circuit_pin, supply_fault_pin, excite_fault_pin} = 3'h0;
    end

    // Raw word is valid only with the pulse; afterwards it shows junk
    task automatic convert(input logic [23:0] raw);
        @(posedge pclk);
        adc_done <= 1'b1;
        adc_raw <= raw;
        @(posedge pclk);
        adc_done <= 1'b0;
        adc_raw <= ~raw;
    endtask

    // Order: open circuit, module supply fault, excitation fault
    task automatic set_pins(input logic [2:0] v);
        @(posedge pclk);
        {open_circuit_pin, supply_fault_pin, excite_fault_pin} <= v;
    endtask
endmodule

// file: testbench/tb_top.sv
/*
 * Self-checking bench: APB master, converter model and scenario tasks.
 * Assumes the design answers APB with one wait state and a 50 MHz pclk.
 */
`timescale 1ns/10ps
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, adc_done, err;
    logic open_circuit_pin, supply_fault_pin, excite_fault_pin;
    logic fir_enable, fir_step, filter_clear, analog_strobe, io_update, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, t1;
    logic [23:0] adc_raw;
    logic [15:0] analog_value;
    int n_fail, n_checks, g;
    time t0;

    sar_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .adc_done(adc_done), .adc_raw(adc_raw), .open_circuit_pin(open_circuit_pin),
        .supply_fault_pin(supply_fault_pin), .excite_fault_pin(excite_fault_pin),
        .fir_enable(fir_enable), .fir_step(fir_step), .filter_clear(filter_clear),
        .analog_value(analog_value), .analog_strobe(analog_strobe), .io_update(io_update), .irq(irq));
    sar_fe_model fe (.pclk(pclk), .adc_done(adc_done), .adc_raw(adc_raw),
        .open_circuit_pin(open_circuit_pin), .supply_fault_pin(supply_fault_pin),
        .excite_fault_pin(excite_fault_pin));

    always #10 pclk = ~pclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Values seen right after an edge are those sampled at it
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk(pready, 1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Cycles between two pulses of io_update or fir_step
    task automatic gap(input bit io);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while ((io ? io_update : fir_step) !== 1'b1 && n < 20000);
        g = 0;
        do begin
            @(posedge pclk);
            g++;
        end while ((io ? io_update : fir_step) !== 1'b1 && g < 20000);
    endtask

    task automatic t_reset;
        rd(sar_pkg::OFF_RATE_MODE); chk(q, 32'h0);
        rd(sar_pkg::OFF_CODED_RATE); chk(q, 32'h0);
        rd(sar_pkg::OFF_FINE_RATE); chk(q, 32'h0);
        wr(sar_pkg::OFF_STATE_FLAGS, 32'hFF);
        rd(sar_pkg::OFF_STATE_FLAGS); chk(q, 32'h20);
        rd(8'h40); chk({q[30:0], err}, 32'h1);
        $display("test reset done");
    endtask

    task automatic t_codes;
        for (int c = 0; c < 16; c++) begin
            wr(sar_pkg::OFF_CODED_RATE, 32'(c));
            cyc(2);
            chk(fir_enable, c < 14);
            rd(sar_pkg::OFF_STATE_FLAGS); chk(q[0], c >= 14);
        end
        fe.convert(24'h123456);
        cyc(1);
        chk(analog_value, sar_pkg::INVALID_RANGE_VALUE);
        wr(sar_pkg::OFF_CODED_RATE, 32'hD);
        gap(0); chk(g >= 6666 && g <= 6667, 1);
        $display("test codes done");
    endtask

    task automatic t_fine;
        wr(sar_pkg::OFF_RATE_MODE, 32'h1);
        wr(sar_pkg::OFF_FINE_RATE, 32'h0);
        cyc(2); chk(fir_enable, 0);
        wr(sar_pkg::OFF_CODED_RATE, 32'hE);
        wr(sar_pkg::OFF_FINE_RATE, 32'hFFFF);
        cyc(2); chk(fir_enable, 1);
        rd(sar_pkg::OFF_STATE_FLAGS); chk(q, 32'h20);
        gap(0); chk(g >= 7629 && g <= 7630, 1);
        gap(0);
        rd(sar_pkg::OFF_STATE_FLAGS); chk(q, 32'h0);
        wr(sar_pkg::OFF_RATE_MODE, 32'h0);
        rd(sar_pkg::OFF_STATE_FLAGS); chk(q, 32'h1);
        wr(sar_pkg::OFF_CODED_RATE, 32'h0);
        $display("test fine done");
    endtask

    task automatic t_faults;
        wr(sar_pkg::OFF_IRQ_CLEAR, 32'h1F);
        wr(sar_pkg::OFF_IRQ_ENABLE, 32'h0);
        fe.set_pins(3'b010);
        cyc(5);
        rd(sar_pkg::OFF_STATE_FLAGS); chk(q, 32'h09);
        chk(filter_clear, 1);
        chk(irq, 0);
        rd(sar_pkg::OFF_IRQ_STATUS); chk(q, 32'h04);
        wr(sar_pkg::OFF_IRQ_ENABLE, 32'h4);
        cyc(2); chk(irq, 1);
        wr(sar_pkg::OFF_IRQ_CLEAR, 32'h4);
        cyc(2); chk(irq, 0);
        rd(sar_pkg::OFF_IRQ_STATUS); chk(q, 32'h0);
        fe.convert(24'h123456);
        cyc(1); chk(analog_value, sar_pkg::INVALID_RANGE_VALUE);
        fe.set_pins(3'b001);
        cyc(5);
        rd(sar_pkg::OFF_STATE_FLAGS); chk(q, 32'h11);
        fe.set_pins(3'b100);
        cyc(5);
        rd(sar_pkg::OFF_STATE_FLAGS); chk(q, 32'h22);
        fe.set_pins(3'b000);
        cyc(5);
        rd(sar_pkg::OFF_STATE_FLAGS); chk(q, 32'h20);
        $display("test faults done");
    endtask

    task automatic t_stamp;
        fe.convert(24'hABCDEF);
        t0 = $time;
        cyc(1); chk(analog_value, 16'hABCD);
        rd(sar_pkg::OFF_CONV_TIME);
        t1 = q;
        // Second conversion lands exactly 500 cycles, 10 us, after the first
        while ($time < t0 + 9960) @(posedge pclk);
        fe.convert(24'h000000);
        rd(sar_pkg::OFF_CONV_TIME); chk(q - t1, 32'hA);
        $display("test stamp done");
    endtask

    task automatic t_io;
        gap(1); chk(g, 2500);
        wr(sar_pkg::OFF_MS_CYCLE, 32'h1);
        gap(1);
        gap(1); chk(g, 5000);
        // Cyclic reads of the latest value stay one 250 us bus cycle apart
        rd(sar_pkg::OFF_ANALOG); chk(q, 32'h0);
        cyc(12500);
        rd(sar_pkg::OFF_ANALOG); chk(q, 32'h0);
        $display("test update done");
    endtask

    // Reset in mid-run must drop irq, fir_enable, io_update, pready and filter_clear and restore the register defaults
    task automatic t_rerun;
        wr(sar_pkg::OFF_RATE_MODE, 32'h1);
        wr(sar_pkg::OFF_IRQ_ENABLE, 32'h1F);
        wr(sar_pkg::OFF_MS_CYCLE, 32'h1);
        @(posedge pclk);
        presetn <= 1'b0;
        cyc(2);
        chk({irq, fir_enable, io_update, pready, filter_clear}, 32'h0);
        presetn <= 1'b1;
        rd(sar_pkg::OFF_RATE_MODE); chk(q, 32'h0);
        rd(sar_pkg::OFF_IRQ_ENABLE); chk(q, 32'h0);
        rd(sar_pkg::OFF_MS_CYCLE); chk(q, 32'h0);
        rd(sar_pkg::OFF_STATE_FLAGS); chk(q, 32'h20);
        $display("test rerun done");
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #1800000;
        n_fail++;
        $display("BAD t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
        give_verdict();
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        n_fail = 0;
        n_checks = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_codes();
        t_fine();
        t_faults();
        t_stamp();
        t_io();
        t_rerun();
        give_verdict();
    end
endmodule
